// ===== include/disa_pkg.sv
package disa_pkg;
  localparam int NREG = 12;
  localparam int NDSP = 3;
  localparam int DW   = 16;
  localparam int AW   = 16;
  localparam int IW   = 14;

  // flag register slots
  localparam int RSYS   = 0;
  localparam int RLOCK  = 1;
  localparam int RACC   = 2;
  localparam int RJACK  = 3;
  localparam int RSIG   = 4;
  localparam int RDSP   = 5;
  localparam int RSHORT = 6;
  localparam int RUP    = 7;
  localparam int RDOWN  = 8;
  localparam int RHEAT  = 9;
  localparam int RPIN   = 10;
  localparam int RTMR   = 11;

  // register indices, byte address is four times the index
  localparam logic [IW-1:0] IDX_G1_DOWN     = 14'h188d;
  localparam logic [IW-1:0] IDX_G1_HEAT     = 14'h188e;
  localparam logic [IW-1:0] IDX_G1_PIN      = 14'h1890;
  localparam logic [IW-1:0] IDX_G1_NONEMPTY = 14'h1895;
  localparam logic [IW-1:0] IDX_G1_FULL     = 14'h1896;
  localparam logic [IW-1:0] IDX_G1_WMARK    = 14'h1897;
  localparam logic [IW-1:0] IDX_G1_DMA      = 14'h1898;
  localparam logic [IW-1:0] IDX_G1_BUSY     = 14'h189d;
  localparam logic [IW-1:0] MASK_DELTA      = 14'h0040;
  localparam logic [IW-1:0] FLAG_IDX [NREG] = '{14'h1900, 14'h1901, 14'h1905, 14'h1906,
    14'h1908, 14'h190a, 14'h190b, 14'h190c, 14'h190d, 14'h190e, 14'h1910, 14'h1914};

  // per-bit edge sensitivity and mask reset value of each flag register
  localparam logic [DW-1:0] FLAG_RISE [NREG] = '{16'h9280, 16'h0100, 16'h0101, 16'h0015,
    16'h0003, 16'hffff, 16'h004f, 16'h0043, 16'h0043, 16'h0007, 16'hffff, 16'h000f};
  localparam logic [DW-1:0] FLAG_FALL [NREG] = '{16'h0000, 16'h0100, 16'h0000, 16'h002a,
    16'h0003, 16'h0000, 16'h0040, 16'h0000, 16'h0000, 16'h0001, 16'hffff, 16'h0000};
  localparam logic [DW-1:0] MASK_RST [NREG] = '{16'hff7f, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};

  // bit positions
  localparam int BIT_COLLISION  = 15;
  localparam int BIT_HOSTERR    = 12;
  localparam int BIT_CLKFAIL    = 9;
  localparam int BIT_BOOT       = 7;
  localparam int BIT_LOCK       = 8;
  localparam int BIT_ACC        = 8;
  localparam int BIT_HP         = 0;
  localparam int BIT_CLAMP_FALL = 5;
  localparam int BIT_CLAMP_RISE = 4;
  localparam int BIT_JB_FALL    = 3;
  localparam int BIT_JB_RISE    = 2;
  localparam int BIT_JA_FALL    = 1;
  localparam int BIT_JA_RISE    = 0;
  localparam int BIT_SPK        = 6;
  localparam int BIT_HEAT_WARN  = 2;
  localparam int BIT_HEAT       = 1;
  localparam int BIT_SHUTDOWN   = 0;
  localparam int BIT_TIMER4     = 3;
endpackage

// ===== include/disa_flag_if.sv
interface disa_flag_if;
  logic [15:0] src;
  logic [15:0] clr;
  logic [15:0] flag;
  modport owner (input src, input clr, output flag);
  modport user  (output src, output clr, input flag);
endinterface

// ===== hw/disa_sync.sv
module disa_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] async,
  output logic      [W-1:0] level
);
  logic [W-1:0] s1Q;
  logic [W-1:0] s2Q;
  logic [W-1:0] s3Q;
  logic [W-1:0] levelQ;

  // first stage feeds only the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1Q <= '0;
      s2Q <= '0;
      s3Q <= '0;
    end else begin
      s1Q <= async;
      s2Q <= s1Q;
      s3Q <= s2Q;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      levelQ <= '0;
    end else begin
      levelQ <= (levelQ & (s2Q ^ s3Q)) | (s3Q & ~(s2Q ^ s3Q));
    end
  end

  assign level = levelQ;
endmodule

// ===== hw/disa_flag_cell.sv
module disa_flag_cell #(
  parameter logic [15:0] RISE = 16'h0000,
  parameter logic [15:0] FALL = 16'h0000
) (
  input  wire logic  clk_sys,
  input  wire logic  rst,
  disa_flag_if.owner bus
);
  logic [15:0] prevQ;
  logic [15:0] flagQ;
  logic [15:0] setD;

  always_comb begin
    setD = (RISE & bus.src & ~prevQ) | (FALL & ~bus.src & prevQ);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prevQ <= '0;
    end else begin
      prevQ <= bus.src;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flagQ <= '0;
    end else begin
      flagQ <= (flagQ & ~bus.clr) | setD;
    end
  end

  assign bus.flag = flagQ;

  property p_clear_one;
    @(posedge clk_sys) disable iff (rst)
    (|(bus.clr & ~setD)) |=> ((bus.flag & $past(bus.clr & ~setD)) == 16'h0000);
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("flag not cleared by a written one");

  property p_zero_holds;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> (($past(bus.flag) & ~$past(bus.clr) & ~bus.flag) == 16'h0000);
  endproperty
  a_zero_holds: assert property (p_zero_holds)
    else $error("flag dropped without a clear");

  property p_set_wins;
    @(posedge clk_sys) disable iff (rst)
    (|setD) |=> ((bus.flag & $past(setD)) == $past(setD));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("edge event lost");
endmodule

// ===== hw/disa_top.sv
// The implementer's own choice: the APB register port.
module disa_top
  import disa_pkg::*;
#(
  parameter int NCH = 4
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [disa_pkg::AW-1:0]       paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          sharedMemCollision,
  input  wire logic                          hostPortError,
  input  wire logic                          systemClockFail,
  input  wire logic                          bootComplete,
  input  wire logic                          loopLock,
  input  wire logic                          accessoryDetectDone,
  input  wire logic                          headphoneDetect,
  input  wire logic                          clampActive,
  input  wire logic                          jackAPin,
  input  wire logic                          jackBPin,
  input  wire logic [1:0]                    levelDetect,
  input  wire logic [15:0]                   dspRaised,
  input  wire logic                          speakerShort,
  input  wire logic [3:0]                    outShort,
  input  wire logic [2:0]                    powerUpDone,
  input  wire logic [2:0]                    powerDownDone,
  input  wire logic                          heatWarning,
  input  wire logic                          heatShutdownTemp,
  input  wire logic                          speakerShutdown,
  input  wire logic [15:0]                   pinLevel,
  input  wire logic [3:0]                    timerEvent,
  input  wire logic [3:0]                    logNonEmpty,
  input  wire logic [3:0]                    logFull,
  input  wire logic [3:0]                    logThreshold,
  input  wire logic [disa_pkg::NDSP-1:0][NCH-1:0] wrChEnable,
  input  wire logic [disa_pkg::NDSP-1:0][NCH-1:0] wrChFilled,
  input  wire logic [disa_pkg::NDSP-1:0][NCH-1:0] rdChEnable,
  input  wire logic [disa_pkg::NDSP-1:0][NCH-1:0] rdChEmptied,
  input  wire logic [disa_pkg::NDSP-1:0]     coreBusy,
  output logic                               irqOut
);
  import disa_pkg::*;

  logic [31:0]     prdataQ;
  logic            preadyQ;
  logic            pslverrQ;
  logic            irqOutQ;
  logic [17:0]     pinSync;
  logic            jackADet;
  logic            jackBDet;
  logic [15:0]     srcVec  [NREG];
  logic [15:0]     clrVec  [NREG];
  logic [15:0]     flagVec [NREG];
  logic [15:0]     maskQ   [NREG];
  logic [NREG-1:0] flagHit;
  logic [NREG-1:0] maskHit;
  logic [NDSP-1:0] dmaDone;
  logic [IW-1:0]   idx;
  logic [15:0]     rdVal;
  logic            hit;
  logic            access;
  logic            done;
  logic            pending;

  // pins idle high, kept inverted so idle matches reset: no false edge after reset
  disa_sync #(
    .W (18)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .async   (~{jackBPin, jackAPin, pinLevel}),
    .level   (pinSync)
  );

  // jack pins pull low on insertion
  assign jackADet = pinSync[16];
  assign jackBDet = pinSync[17];

  // spread a three-bit sequence group onto bits 6, 1, 0
  function automatic logic [15:0] spread3(input logic [2:0] v);
    spread3 = {9'h000, v[2], 4'h0, v[1:0]};
  endfunction

  always_comb begin
    for (int k = 0; k < NREG; k++) begin
      srcVec[k] = 16'h0000;
    end
    srcVec[RSYS][BIT_COLLISION]  = sharedMemCollision;
    srcVec[RSYS][BIT_HOSTERR]    = hostPortError;
    srcVec[RSYS][BIT_CLKFAIL]    = systemClockFail;
    srcVec[RSYS][BIT_BOOT]       = bootComplete;
    srcVec[RLOCK][BIT_LOCK]      = loopLock;
    srcVec[RACC][BIT_ACC]        = accessoryDetectDone;
    srcVec[RACC][BIT_HP]         = headphoneDetect;
    srcVec[RJACK][BIT_CLAMP_FALL] = clampActive;
    srcVec[RJACK][BIT_CLAMP_RISE] = clampActive;
    srcVec[RJACK][BIT_JB_FALL]   = jackBDet;
    srcVec[RJACK][BIT_JB_RISE]   = jackBDet;
    srcVec[RJACK][BIT_JA_FALL]   = jackADet;
    srcVec[RJACK][BIT_JA_RISE]   = jackADet;
    srcVec[RSIG][1:0]            = levelDetect;
    srcVec[RDSP]                 = dspRaised;
    srcVec[RSHORT][BIT_SPK]      = speakerShort;
    srcVec[RSHORT][3:0]          = outShort;
    srcVec[RUP]                  = spread3(powerUpDone);
    srcVec[RDOWN]                = spread3(powerDownDone);
    srcVec[RHEAT][BIT_HEAT_WARN] = heatWarning;
    srcVec[RHEAT][BIT_HEAT]      = heatShutdownTemp;
    srcVec[RHEAT][BIT_SHUTDOWN]  = speakerShutdown;
    // pin n at bit n-1, inverted image has same edges
    srcVec[RPIN]                 = pinSync[15:0];
    srcVec[RTMR][3:0]            = timerEvent;
  end

  // done only when every enabled channel is serviced
  genvar d;
  generate
    for (d = 0; d < NDSP; d++) begin : g_dma
      assign dmaDone[d] = (&(~wrChEnable[d] | wrChFilled[d]))
                        & (&(~rdChEnable[d] | rdChEmptied[d]));
    end
  endgenerate

  // apb: one wait state, answer registered
  assign access = psel & penable;
  assign done   = access & preadyQ;
  assign idx    = paddr[AW-1:2];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      preadyQ <= 1'b0;
    end else begin
      preadyQ <= access & ~preadyQ;
    end
  end

  disa_flag_if fIf [NREG] ();

  genvar k;
  generate
    for (k = 0; k < NREG; k++) begin : g_flag
      assign flagHit[k] = (idx == FLAG_IDX[k]) && (paddr[1:0] == 2'h0);
      assign maskHit[k] = (idx == FLAG_IDX[k] + MASK_DELTA) && (paddr[1:0] == 2'h0);
      // clear strobe only at the completing edge
      assign clrVec[k] = (done && pwrite && flagHit[k]) ? pwdata[15:0] : 16'h0000;
      assign fIf[k].src  = srcVec[k];
      assign fIf[k].clr  = clrVec[k];
      assign flagVec[k]  = fIf[k].flag;

      disa_flag_cell #(
        .RISE (FLAG_RISE[k]),
        .FALL (FLAG_FALL[k])
      ) u_cell (
        .clk_sys (clk_sys),
        .rst     (rst),
        .bus     (fIf[k])
      );

      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          maskQ[k] <= MASK_RST[k];
        end else if (done && pwrite && maskHit[k]) begin
          maskQ[k] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  always_comb begin
    rdVal = 16'h0000;
    hit   = 1'b0;
    for (int j = 0; j < NREG; j++) begin
      if (flagHit[j]) begin
        hit   = 1'b1;
        rdVal = flagVec[j];
      end
      if (maskHit[j]) begin
        hit   = 1'b1;
        rdVal = maskQ[j];
      end
    end
    if (paddr[1:0] == 2'h0) begin
      case (idx)
        IDX_G1_DOWN: begin
          hit   = 1'b1;
          rdVal = spread3(powerDownDone);
        end
        IDX_G1_HEAT: begin
          hit   = 1'b1;
          rdVal = {13'h0000, heatWarning, heatShutdownTemp, speakerShutdown};
        end
        IDX_G1_PIN: begin
          hit   = 1'b1;
          rdVal = ~pinSync[15:0];
        end
        IDX_G1_NONEMPTY: begin
          hit   = 1'b1;
          rdVal = {12'h000, logNonEmpty};
        end
        IDX_G1_FULL: begin
          hit   = 1'b1;
          rdVal = {12'h000, logFull};
        end
        IDX_G1_WMARK: begin
          hit   = 1'b1;
          rdVal = {12'h000, logThreshold};
        end
        IDX_G1_DMA: begin
          hit   = 1'b1;
          rdVal = {13'h0000, dmaDone};
        end
        IDX_G1_BUSY: begin
          hit   = 1'b1;
          rdVal = {13'h0000, coreBusy};
        end
        default: begin
        end
      endcase
    end
  end

  // data and error land together with pready
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdataQ  <= 32'h0000_0000;
      pslverrQ <= 1'b0;
    end else if (access && !preadyQ) begin
      prdataQ  <= (hit && !pwrite) ? {16'h0000, rdVal} : 32'h0000_0000;
      pslverrQ <= ~hit;
    end else begin
      pslverrQ <= 1'b0;
    end
  end

  always_comb begin
    pending = 1'b0;
    for (int j = 0; j < NREG; j++) begin
      pending = pending | (|(flagVec[j] & ~maskQ[j]));
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irqOutQ <= 1'b0;
    end else begin
      irqOutQ <= pending;
    end
  end

  assign prdata  = prdataQ;
  assign pready  = preadyQ;
  assign pslverr = pslverrQ;
  assign irqOut  = irqOutQ;

  property p_mask_reset;
    @(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> (maskQ[RSYS][BIT_BOOT] == 1'b0) && (maskQ[RSYS][BIT_LOCK] == 1'b1)
                   && (maskQ[RPIN] == 16'hffff);
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask reset value wrong");

  property p_irq_on;
    @(posedge clk_sys) disable iff (rst)
    pending [*2] |-> irqOut;
  endproperty
  a_irq_on: assert property (p_irq_on)
    else $error("interrupt missing for unmasked flag");

  property p_irq_off;
    @(posedge clk_sys) disable iff (rst)
    (!pending) [*2] |-> !irqOut;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt without unmasked flag");

  property p_boot_rise;
    @(posedge clk_sys) disable iff (rst)
    $rose(bootComplete) |=> flagVec[RSYS][BIT_BOOT];
  endproperty
  a_boot_rise: assert property (p_boot_rise)
    else $error("boot flag not latched");

  property p_lock_both;
    @(posedge clk_sys) disable iff (rst)
    $changed(loopLock) |=> flagVec[RLOCK][BIT_LOCK];
  endproperty
  a_lock_both: assert property (p_lock_both)
    else $error("lock flag missed an edge");

  property p_clamp_fall;
    @(posedge clk_sys) disable iff (rst)
    $fell(clampActive) |=> flagVec[RJACK][BIT_CLAMP_FALL];
  endproperty
  a_clamp_fall: assert property (p_clamp_fall)
    else $error("clamp fall flag not latched");

  property p_pin_edge;
    @(posedge clk_sys) disable iff (rst)
    $changed(pinSync[0]) |=> flagVec[RPIN][0];
  endproperty
  a_pin_edge: assert property (p_pin_edge)
    else $error("pin flag missed an edge");

  property p_timer_rise;
    @(posedge clk_sys) disable iff (rst)
    $rose(timerEvent[BIT_TIMER4]) |=> flagVec[RTMR][BIT_TIMER4];
  endproperty
  a_timer_rise: assert property (p_timer_rise)
    else $error("timer flag not latched");
endmodule

// ===== tb/disa_pin_model.sv
module disa_pin_model (
  input  wire logic [15:0] pinDrive,
  input  wire logic [15:0] pinOe_n,
  input  wire logic [1:0]  jackPresent,
  output logic      [15:0] pinLevel,
  output logic             jackAPin,
  output logic             jackBPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-ups: a released pin reads high, never a stale level
  assign pinLevel = (pinDrive & ~pinOe_n) | pinOe_n;
  // a plugged jack pulls its detect pin low
  assign jackAPin = ~jackPresent[0];
  assign jackBPin = ~jackPresent[1];
endmodule

// ===== tb/tb_top.sv
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("Error %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import disa_pkg::*;
  localparam logic [15:0] riseExp [NREG] = '{16'h9280, 16'h0100, 16'h0101, 16'h0015,
    16'h0003, 16'hffff, 16'h004f, 16'h0043, 16'h0043, 16'h0007, 16'hffff, 16'h000f};
  localparam logic [15:0] fallExp [NREG] = '{16'h0000, 16'h0100, 16'h0000, 16'h002a,
    16'h0003, 16'h0000, 16'h0040, 16'h0000, 16'h0000, 16'h0001, 16'hffff, 16'h0000};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irqOut, err, jackAPin, jackBPin;
  logic sharedMemCollision = 0, hostPortError = 0, systemClockFail = 0, bootComplete = 0;
  logic loopLock = 0, accessoryDetectDone = 0, headphoneDetect = 0, clampActive = 0;
  logic speakerShort = 0, heatWarning = 0, heatShutdownTemp = 0, speakerShutdown = 0;
  logic [1:0] levelDetect = '0, jackPresent = '0;
  logic [15:0] dspRaised = '0, pinDrive = '0, pinOe_n = '1, pinLevel;
  logic [3:0] outShort = '0, timerEvent = '0, logNonEmpty = '0, logFull = '0, logThreshold = '0;
  logic [2:0] powerUpDone = '0, powerDownDone = '0, coreBusy = '0;
  logic [NDSP-1:0][3:0] wrChEnable = '0, wrChFilled = '0, rdChEnable = '0, rdChEmptied = '0;
  int fails = 0;
  int checked = 0;
  int cyc = 0;

  disa_pin_model disa_pin_model_inst (.pinDrive(pinDrive), .pinOe_n(pinOe_n),
    .jackPresent(jackPresent), .pinLevel(pinLevel), .jackAPin(jackAPin), .jackBPin(jackBPin));

  disa_top #(.NCH(4)) disa_top_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sharedMemCollision(sharedMemCollision),
    .hostPortError(hostPortError), .systemClockFail(systemClockFail),
    .bootComplete(bootComplete), .loopLock(loopLock),
    .accessoryDetectDone(accessoryDetectDone), .headphoneDetect(headphoneDetect),
    .clampActive(clampActive), .jackAPin(jackAPin), .jackBPin(jackBPin),
    .levelDetect(levelDetect), .dspRaised(dspRaised), .speakerShort(speakerShort),
    .outShort(outShort), .powerUpDone(powerUpDone), .powerDownDone(powerDownDone),
    .heatWarning(heatWarning), .heatShutdownTemp(heatShutdownTemp),
    .speakerShutdown(speakerShutdown), .pinLevel(pinLevel), .timerEvent(timerEvent),
    .logNonEmpty(logNonEmpty), .logFull(logFull), .logThreshold(logThreshold),
    .wrChEnable(wrChEnable), .wrChFilled(wrChFilled), .rdChEnable(rdChEnable),
    .rdChEmptied(rdChEmptied), .coreBusy(coreBusy), .irqOut(irqOut));

  always #10 clk_sys = ~clk_sys;

  task automatic final_report;
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // hang guard, well above the expected run of under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      final_report;
    end
  end

  task automatic apb(input logic w, input logic [IW-1:0] idx, input logic [15:0] wd,
                     output logic [31:0] rdat, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    // no assumed latency: only the hang guard ends a stall
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rdat = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wrReg(input logic [IW-1:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d, rd, err);
  endtask

  task automatic rdChk(input logic [IW-1:0] idx, input logic [15:0] e, input string nm);
    apb(1'b0, idx, 16'h0000, rd, err);
    `CHK(nm, {16'h0000, e}, rd)
  endtask

  // drive the sources of one flag word from a bit image of that word
  task automatic setSrc(input int r, input logic [15:0] v);
    case (r)
      RSYS: begin
        sharedMemCollision <= v[15];
        hostPortError <= v[12];
        systemClockFail <= v[9];
        bootComplete <= v[7];
      end
      RLOCK: loopLock <= v[8];
      RACC: begin
        accessoryDetectDone <= v[8];
        headphoneDetect <= v[0];
      end
      RJACK: begin
        clampActive <= v[4];
        jackPresent <= {v[2], v[0]};
      end
      RSIG: levelDetect <= v[1:0];
      RDSP: dspRaised <= v;
      RSHORT: begin
        speakerShort <= v[6];
        outShort <= v[3:0];
      end
      RUP: powerUpDone <= {v[6], v[1:0]};
      RDOWN: powerDownDone <= {v[6], v[1:0]};
      RHEAT: begin
        heatWarning <= v[2];
        heatShutdownTemp <= v[1];
        speakerShutdown <= v[0];
      end
      // pins are driven inverted so each step is a real edge after pull-up idle
      RPIN: begin
        pinOe_n <= 16'h0000;
        pinDrive <= ~v;
      end
      default: timerEvent <= v[3:0];
    endcase
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (10) @(posedge clk_sys);
    for (int r = 0; r < NREG; r++) begin
      rdChk(FLAG_IDX[r] + MASK_DELTA, (r == RSYS) ? 16'hff7f : 16'hffff, "mask reset");
      wrReg(FLAG_IDX[r], 16'hffff);
    end
    for (int r = 0; r < NREG; r++) begin
      rdChk(FLAG_IDX[r], 16'h0000, "flag idle");
      setSrc(r, riseExp[r] | fallExp[r]);
      repeat (8) @(posedge clk_sys);
      rdChk(FLAG_IDX[r], riseExp[r], "rise flags");
      `CHK("irq after rise", (r == RSYS), irqOut)
      wrReg(FLAG_IDX[r], 16'h0000);
      rdChk(FLAG_IDX[r], riseExp[r], "write zero");
      wrReg(FLAG_IDX[r], 16'hffff);
      rdChk(FLAG_IDX[r], 16'h0000, "cleared");
      `CHK("irq after clear", 1'b0, irqOut)
      setSrc(r, 16'h0000);
      repeat (8) @(posedge clk_sys);
      rdChk(FLAG_IDX[r], fallExp[r], "fall flags");
      wrReg(FLAG_IDX[r], 16'hffff);
    end
    powerDownDone <= 3'b101;
    heatWarning <= 1'b1;
    speakerShutdown <= 1'b1;
    pinDrive <= 16'ha5c3;
    logNonEmpty <= 4'h1;
    logFull <= 4'h8;
    logThreshold <= 4'h6;
    wrChEnable <= {4'h0, 4'h1, 4'hf};
    wrChFilled <= {4'h0, 4'h0, 4'hf};
    rdChEnable <= {4'h2, 4'h0, 4'h3};
    rdChEmptied <= {4'h0, 4'h0, 4'h3};
    coreBusy <= 3'b010;
    repeat (8) @(posedge clk_sys);
    rdChk(IDX_G1_DOWN, 16'h0041, "raw power down");
    rdChk(IDX_G1_HEAT, 16'h0005, "raw thermal");
    rdChk(IDX_G1_PIN, 16'ha5c3, "raw pins");
    `CHK("read error", 1'b0, err)
    rdChk(IDX_G1_NONEMPTY, 16'h0001, "raw not empty");
    rdChk(IDX_G1_FULL, 16'h0008, "raw full");
    rdChk(IDX_G1_WMARK, 16'h0006, "raw threshold");
    rdChk(IDX_G1_DMA, 16'h0001, "raw transfer");
    wrReg(IDX_G1_BUSY, 16'hffff);
    rdChk(IDX_G1_BUSY, 16'h0002, "raw busy");
    apb(1'b0, 14'h0000, 16'h0000, rd, err);
    `CHK("unmapped error", 1'b1, err)
    // unmasked timer flag drives the line; masking alone drops it
    wrReg(FLAG_IDX[RTMR] + MASK_DELTA, 16'hfff7);
    timerEvent <= 4'h8;
    repeat (8) @(posedge clk_sys);
    `CHK("irq unmasked", 1'b1, irqOut)
    rdChk(FLAG_IDX[RTMR] + MASK_DELTA, 16'hfff7, "mask readback");
    wrReg(FLAG_IDX[RTMR] + MASK_DELTA, 16'hffff);
    repeat (2) @(posedge clk_sys);
    `CHK("irq masked", 1'b0, irqOut)
    wrReg(FLAG_IDX[RTMR] + MASK_DELTA, 16'hfff7);
    repeat (2) @(posedge clk_sys);
    `CHK("irq held flag", 1'b1, irqOut)
    wrReg(FLAG_IDX[RTMR], 16'h0008);
    repeat (2) @(posedge clk_sys);
    `CHK("irq cleared", 1'b0, irqOut)
    final_report;
  end
endmodule
